// ### common/toolg_pkg.sv
// Constants shared by the thermal overload output logic
package toolg_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ALARM1_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_ALARM2_LEVEL = 8'h08;
    localparam logic [7:0] ADDR_LOCKOUT_LEVEL = 8'h0C;
    localparam logic [7:0] ADDR_TRIP_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_TRIP_DELAY = 8'h14;
    localparam logic [7:0] ADDR_SERVICE_FACTOR = 8'h18;
    localparam logic [7:0] ADDR_AMB_K_MAX = 8'h1C;
    localparam logic [7:0] ADDR_AMB_K_MIN = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_USED_FACTORS = 8'h28;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_MODE_LSB = 4;

    // ------------------------------------------------------------
    // Widths and reset values (levels in 0.1 %, factors in 0.01)
    // ------------------------------------------------------------
    localparam int LEVEL_W = 11;
    localparam int DELAY_W = 20;
    localparam int FACTOR_W = 10;
    localparam int CURRENT_W = 16;
    localparam logic [10:0] ALARM1_LEVEL_RST = 11'h190;
    localparam logic [10:0] ALARM2_LEVEL_RST = 11'h190;
    localparam logic [10:0] LOCKOUT_LEVEL_RST = 11'h320;
    localparam logic [10:0] TRIP_LEVEL_RST = 11'h3E8;
    localparam logic [19:0] TRIP_DELAY_RST = 20'h00000;
    localparam logic [3:0] ENABLES_RST = 4'h0;
    localparam logic [9:0] FACTOR_UNITY = 10'h064;
    localparam logic [9:0] FACTOR_MAX = 10'h1F4;
    localparam logic [9:0] FACTOR_ZERO = 10'h000;

    // ------------------------------------------------------------
    // Load classification limits (current in 0.01 x nominal)
    // ------------------------------------------------------------
    localparam logic [15:0] LIGHT_LOAD_LIMIT = 16'h0001;
    localparam logic [15:0] HIGH_OVERLOAD_LIMIT = 16'h00C8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int DELAY_STEP_US = 5000;
    localparam int CLK_MHZ = 250;
    localparam int DELAY_STEP_CYCLES = DELAY_STEP_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_ON = 3'h0;
    localparam logic [2:0] MODE_BLOCKED = 3'h1;
    localparam logic [2:0] MODE_TEST = 3'h2;
    localparam logic [2:0] MODE_TEST_BLOCKED = 3'h3;
    localparam logic [2:0] MODE_OFF = 3'h4;

    // ------------------------------------------------------------
    // Output condition and load status codes
    // ------------------------------------------------------------
    localparam logic [2:0] COND_NORMAL = 3'h0;
    localparam logic [2:0] COND_ALARM1 = 3'h1;
    localparam logic [2:0] COND_ALARM2 = 3'h2;
    localparam logic [2:0] COND_LOCKOUT = 3'h3;
    localparam logic [2:0] COND_TRIP = 3'h4;
    localparam logic [2:0] COND_BLOCKED = 3'h5;
    localparam logic [1:0] LOAD_LIGHT = 2'h0;
    localparam logic [1:0] LOAD_NORMAL = 2'h1;
    localparam logic [1:0] LOAD_OVERLOADING = 2'h2;
    localparam logic [1:0] LOAD_HIGH = 2'h3;

    typedef enum logic [3:0] {
        TOLG_IDLE = 4'b0001,
        TOLG_TIMING = 4'b0010,
        TOLG_TRIPPED = 4'b0100,
        TOLG_BLOCKED = 4'b1000
    } tolg_phase_t;

endpackage : toolg_pkg

// ### verilog/tolg_output_logic.sv
// Threshold, blocking and status logic of the thermal overload stage
`timescale 1ns/1ps

module tolg_output_logic #(
    parameter int STEP_CYCLES = toolg_pkg::DELAY_STEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic cycleTick,
    input wire logic [toolg_pkg::LEVEL_W-1:0] thermalCapacity,
    input wire logic [toolg_pkg::CURRENT_W-1:0] measCurrent,
    input wire logic [toolg_pkg::CURRENT_W-1:0] pickupCurrent,
    input wire logic blockIn,
    output logic alarm1Out,
    output logic alarm2Out,
    output logic lockoutOut,
    output logic tripOut,
    output logic startInd,
    output logic blockedInd,
    output logic [2:0] condition,
    output logic [1:0] loadStatus,
    output logic serviceFactorAlarm,
    output logic ambientAlarm,
    output logic [toolg_pkg::FACTOR_W-1:0] usedServiceFactor,
    output logic [toolg_pkg::FACTOR_W-1:0] usedAmbientK
);

    localparam int PRE_W = $clog2(STEP_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

    typedef struct packed {
        logic [3:0] enables;
        logic [2:0] mode;
        logic [toolg_pkg::LEVEL_W-1:0] alarm1Level;
        logic [toolg_pkg::LEVEL_W-1:0] alarm2Level;
        logic [toolg_pkg::LEVEL_W-1:0] lockoutLevel;
        logic [toolg_pkg::LEVEL_W-1:0] tripLevel;
        logic [toolg_pkg::DELAY_W-1:0] tripDelay;
        logic [toolg_pkg::FACTOR_W-1:0] serviceFactor;
        logic [toolg_pkg::FACTOR_W-1:0] ambKMax;
        logic [toolg_pkg::FACTOR_W-1:0] ambKMin;
        logic blockSync1;
        logic blockSync2;
        logic blockSample;
        toolg_pkg::tolg_phase_t phase;
        logic [PRE_W-1:0] prescale;
        logic [toolg_pkg::DELAY_W-1:0] delayCount;
        logic alarm1Out;
        logic alarm2Out;
        logic lockoutOut;
        logic tripOut;
        logic startInd;
        logic blockedInd;
        logic [2:0] condition;
        logic [1:0] loadStatus;
        logic serviceFactorAlarm;
        logic ambientAlarm;
        logic [toolg_pkg::FACTOR_W-1:0] usedServiceFactor;
        logic [toolg_pkg::FACTOR_W-1:0] usedAmbientK;
        logic [31:0] regRdata;
    } tolg_state_t;

    tolg_state_t state;
    tolg_state_t next_state;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic factorBad(
        input logic [toolg_pkg::FACTOR_W-1:0] f
    );
        return (f == toolg_pkg::FACTOR_ZERO) || (f > toolg_pkg::FACTOR_MAX);
    endfunction : factorBad

    function automatic logic reaches(
        input logic en,
        input logic [toolg_pkg::LEVEL_W-1:0] cap,
        input logic [toolg_pkg::LEVEL_W-1:0] level
    );
        return en && (cap >= level);
    endfunction : reaches

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic modeOff;
    logic modeBlocked;
    logic modeTest;
    logic blockNow;
    logic pick1;
    logic pick2;
    logic pickLock;
    logic pickTrip;
    logic anyPick;
    logic delayDone;
    logic tripSignal;
    logic sfBad;
    logic ambBad;
    logic [31:0] readData;

    always_comb begin
        next_state = state;
        modeOff = (state.mode != toolg_pkg::MODE_ON)
            && (state.mode != toolg_pkg::MODE_BLOCKED)
            && (state.mode != toolg_pkg::MODE_TEST)
            && (state.mode != toolg_pkg::MODE_TEST_BLOCKED);
        modeBlocked = (state.mode == toolg_pkg::MODE_BLOCKED)
            || (state.mode == toolg_pkg::MODE_TEST_BLOCKED);
        modeTest = (state.mode == toolg_pkg::MODE_TEST)
            || (state.mode == toolg_pkg::MODE_TEST_BLOCKED);

        // Blocking input synchroniser and per-cycle sample
        next_state.blockSync1 = blockIn;
        next_state.blockSync2 = state.blockSync1;
        blockNow = cycleTick ? (state.blockSync2 || modeBlocked)
            : state.blockSample;
        next_state.blockSample = blockNow;

        // Live settings feed the comparators directly
        pick1 = reaches(state.enables[0], thermalCapacity,
            state.alarm1Level);
        pick2 = reaches(state.enables[1], thermalCapacity,
            state.alarm2Level);
        pickLock = reaches(state.enables[2], thermalCapacity,
            state.lockoutLevel);
        pickTrip = reaches(state.enables[3], thermalCapacity,
            state.tripLevel);
        anyPick = pick1 || pick2 || pickLock || pickTrip;
        delayDone = (state.delayCount >= state.tripDelay);

        // Extra trip delay counted in 5 ms steps
        if (state.phase == toolg_pkg::TOLG_TIMING) begin
            if (state.prescale == PRE_LAST) begin
                next_state.prescale = '0;
                if (!delayDone) begin
                    next_state.delayCount = state.delayCount + 1'b1;
                end
            end else begin
                next_state.prescale = state.prescale + 1'b1;
            end
        end else begin
            next_state.prescale = '0;
            next_state.delayCount = '0;
        end

        if (cycleTick) begin
            unique case (state.phase)
                toolg_pkg::TOLG_IDLE: begin
                    if (pickTrip && blockNow) begin
                        next_state.phase = toolg_pkg::TOLG_BLOCKED;
                    end else if (pickTrip && (state.tripDelay == '0)) begin
                        next_state.phase = toolg_pkg::TOLG_TRIPPED;
                    end else if (pickTrip) begin
                        next_state.phase = toolg_pkg::TOLG_TIMING;
                    end
                end
                toolg_pkg::TOLG_TIMING: begin
                    if (!pickTrip) begin
                        next_state.phase = toolg_pkg::TOLG_IDLE;
                    end else if (blockNow) begin
                        next_state.phase = toolg_pkg::TOLG_BLOCKED;
                    end else if (delayDone) begin
                        next_state.phase = toolg_pkg::TOLG_TRIPPED;
                    end
                end
                toolg_pkg::TOLG_TRIPPED: begin
                    if (!pickTrip) begin
                        next_state.phase = toolg_pkg::TOLG_IDLE;
                    end else if (blockNow) begin
                        next_state.phase = toolg_pkg::TOLG_BLOCKED;
                    end
                end
                toolg_pkg::TOLG_BLOCKED: begin
                    if (!pickTrip || !blockNow) begin
                        next_state.phase = toolg_pkg::TOLG_IDLE;
                    end
                end
                default: begin
                    next_state.phase = toolg_pkg::TOLG_IDLE;
                end
            endcase
            if (modeOff) begin
                next_state.phase = toolg_pkg::TOLG_IDLE;
            end
        end

        tripSignal = (next_state.phase == toolg_pkg::TOLG_TRIPPED);
        next_state.startInd = (next_state.phase == toolg_pkg::TOLG_TIMING)
            || tripSignal;
        next_state.blockedInd = !modeOff && anyPick && blockNow;

        // Output signals, suppressed while blocked, off or in test
        if (cycleTick) begin
            next_state.alarm1Out = pick1 && !blockNow && !modeOff
                && !modeTest;
            next_state.alarm2Out = pick2 && !blockNow && !modeOff
                && !modeTest;
            next_state.lockoutOut = pickLock && !blockNow && !modeOff
                && !modeTest;
            next_state.tripOut = tripSignal && !modeTest;

            // Output condition, highest ranking first
            if (modeOff) begin
                next_state.condition = toolg_pkg::COND_NORMAL;
            end else if (next_state.blockedInd) begin
                next_state.condition = toolg_pkg::COND_BLOCKED;
            end else if (tripSignal) begin
                next_state.condition = toolg_pkg::COND_TRIP;
            end else if (pickLock) begin
                next_state.condition = toolg_pkg::COND_LOCKOUT;
            end else if (pick2) begin
                next_state.condition = toolg_pkg::COND_ALARM2;
            end else if (pick1) begin
                next_state.condition = toolg_pkg::COND_ALARM1;
            end else begin
                next_state.condition = toolg_pkg::COND_NORMAL;
            end
        end

        // Load status
        if (measCurrent < toolg_pkg::LIGHT_LOAD_LIMIT) begin
            next_state.loadStatus = toolg_pkg::LOAD_LIGHT;
        end else if (measCurrent > toolg_pkg::HIGH_OVERLOAD_LIMIT) begin
            next_state.loadStatus = toolg_pkg::LOAD_HIGH;
        end else if (measCurrent > pickupCurrent) begin
            next_state.loadStatus = toolg_pkg::LOAD_OVERLOADING;
        end else begin
            next_state.loadStatus = toolg_pkg::LOAD_NORMAL;
        end

        // Setting faults and substituted factors
        sfBad = factorBad(state.serviceFactor);
        ambBad = factorBad(state.ambKMax) || factorBad(state.ambKMin);
        next_state.serviceFactorAlarm = sfBad;
        next_state.ambientAlarm = ambBad;
        next_state.usedServiceFactor = sfBad ? toolg_pkg::FACTOR_UNITY
            : state.serviceFactor;
        next_state.usedAmbientK = ambBad ? toolg_pkg::FACTOR_UNITY
            : toolg_pkg::FACTOR_ZERO;

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (regWrite) begin
            unique case (regAddr)
                toolg_pkg::ADDR_CTRL: begin
                    next_state.enables = regWdata[toolg_pkg::CTRL_EN_LSB +: 4];
                    next_state.mode = regWdata[toolg_pkg::CTRL_MODE_LSB +: 3];
                end
                toolg_pkg::ADDR_ALARM1_LEVEL: begin
                    next_state.alarm1Level = regWdata[toolg_pkg::LEVEL_W-1:0];
                end
                toolg_pkg::ADDR_ALARM2_LEVEL: begin
                    next_state.alarm2Level = regWdata[toolg_pkg::LEVEL_W-1:0];
                end
                toolg_pkg::ADDR_LOCKOUT_LEVEL: begin
                    next_state.lockoutLevel = regWdata[toolg_pkg::LEVEL_W-1:0];
                end
                toolg_pkg::ADDR_TRIP_LEVEL: begin
                    next_state.tripLevel = regWdata[toolg_pkg::LEVEL_W-1:0];
                end
                toolg_pkg::ADDR_TRIP_DELAY: begin
                    next_state.tripDelay = regWdata[toolg_pkg::DELAY_W-1:0];
                end
                toolg_pkg::ADDR_SERVICE_FACTOR: begin
                    next_state.serviceFactor =
                        regWdata[toolg_pkg::FACTOR_W-1:0];
                end
                toolg_pkg::ADDR_AMB_K_MAX: begin
                    next_state.ambKMax = regWdata[toolg_pkg::FACTOR_W-1:0];
                end
                toolg_pkg::ADDR_AMB_K_MIN: begin
                    next_state.ambKMin = regWdata[toolg_pkg::FACTOR_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------
        // Register reads, data valid the following cycle only
        // --------------------------------------------------------
        readData = '0;
        unique case (regAddr)
            toolg_pkg::ADDR_CTRL: begin
                readData[toolg_pkg::CTRL_EN_LSB +: 4] = state.enables;
                readData[toolg_pkg::CTRL_MODE_LSB +: 3] = state.mode;
            end
            toolg_pkg::ADDR_ALARM1_LEVEL: begin
                readData[toolg_pkg::LEVEL_W-1:0] = state.alarm1Level;
            end
            toolg_pkg::ADDR_ALARM2_LEVEL: begin
                readData[toolg_pkg::LEVEL_W-1:0] = state.alarm2Level;
            end
            toolg_pkg::ADDR_LOCKOUT_LEVEL: begin
                readData[toolg_pkg::LEVEL_W-1:0] = state.lockoutLevel;
            end
            toolg_pkg::ADDR_TRIP_LEVEL: begin
                readData[toolg_pkg::LEVEL_W-1:0] = state.tripLevel;
            end
            toolg_pkg::ADDR_TRIP_DELAY: begin
                readData[toolg_pkg::DELAY_W-1:0] = state.tripDelay;
            end
            toolg_pkg::ADDR_SERVICE_FACTOR: begin
                readData[toolg_pkg::FACTOR_W-1:0] = state.serviceFactor;
            end
            toolg_pkg::ADDR_AMB_K_MAX: begin
                readData[toolg_pkg::FACTOR_W-1:0] = state.ambKMax;
            end
            toolg_pkg::ADDR_AMB_K_MIN: begin
                readData[toolg_pkg::FACTOR_W-1:0] = state.ambKMin;
            end
            toolg_pkg::ADDR_STATUS: begin
                readData[13:0] = {state.ambientAlarm,
                    state.serviceFactorAlarm, state.loadStatus,
                    state.condition, state.blockedInd, state.startInd,
                    state.phase[2], state.tripOut, state.lockoutOut,
                    state.alarm2Out, state.alarm1Out};
            end
            toolg_pkg::ADDR_USED_FACTORS: begin
                readData[2*toolg_pkg::FACTOR_W-1:0] =
                    {state.usedAmbientK, state.usedServiceFactor};
            end
            default: begin
            end
        endcase
        next_state.regRdata = regRead ? readData : '0;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
            state.enables <= toolg_pkg::ENABLES_RST;
            state.mode <= toolg_pkg::MODE_ON;
            state.alarm1Level <= toolg_pkg::ALARM1_LEVEL_RST;
            state.alarm2Level <= toolg_pkg::ALARM2_LEVEL_RST;
            state.lockoutLevel <= toolg_pkg::LOCKOUT_LEVEL_RST;
            state.tripLevel <= toolg_pkg::TRIP_LEVEL_RST;
            state.tripDelay <= toolg_pkg::TRIP_DELAY_RST;
            state.serviceFactor <= toolg_pkg::FACTOR_UNITY;
            state.ambKMax <= toolg_pkg::FACTOR_UNITY;
            state.ambKMin <= toolg_pkg::FACTOR_UNITY;
            state.phase <= toolg_pkg::TOLG_IDLE;
            state.loadStatus <= toolg_pkg::LOAD_LIGHT;
            state.usedServiceFactor <= toolg_pkg::FACTOR_UNITY;
            state.usedAmbientK <= toolg_pkg::FACTOR_ZERO;
        end else begin
            state <= next_state;
        end
    end

    assign regRdata = state.regRdata;
    assign alarm1Out = state.alarm1Out;
    assign alarm2Out = state.alarm2Out;
    assign lockoutOut = state.lockoutOut;
    assign tripOut = state.tripOut;
    assign startInd = state.startInd;
    assign blockedInd = state.blockedInd;
    assign condition = state.condition;
    assign loadStatus = state.loadStatus;
    assign serviceFactorAlarm = state.serviceFactorAlarm;
    assign ambientAlarm = state.ambientAlarm;
    assign usedServiceFactor = state.usedServiceFactor;
    assign usedAmbientK = state.usedAmbientK;

endmodule : tolg_output_logic

// ### verification/tolg_properties.sv
// Port-level assertions for the thermal overload output logic
`timescale 1ns/1ps
module tolg_properties (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cycleTick,
    input wire logic blockIn,
    input wire logic [15:0] measCurrent,
    input wire logic [15:0] pickupCurrent,
    input wire logic alarm1Out,
    input wire logic alarm2Out,
    input wire logic lockoutOut,
    input wire logic tripOut,
    input wire logic startInd,
    input wire logic blockedInd,
    input wire logic [2:0] condition,
    input wire logic [1:0] loadStatus,
    input wire logic serviceFactorAlarm,
    input wire logic ambientAlarm,
    input wire logic [9:0] usedServiceFactor,
    input wire logic [9:0] usedAmbientK
);
    // ------
    // Checks
    // ------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_normal_quiet: assert property (condition == 3'h0 |->
        !(alarm1Out | alarm2Out | lockoutOut | tripOut))
        else $error("output in normal");
    a_light_load: assert property (measCurrent == 16'h0000 |=>
        loadStatus == 2'h0) else $error("light load wrong");
    a_normal_load: assert property (measCurrent != 16'h0000 &&
        measCurrent < pickupCurrent |=> loadStatus == 2'h1)
        else $error("normal load wrong");
    a_over_load: assert property (measCurrent > pickupCurrent &&
        measCurrent <= 16'h00C8 |=> loadStatus == 2'h2)
        else $error("overloading wrong");
    a_high_load: assert property (measCurrent > 16'h00C8 |=>
        loadStatus == 2'h3) else $error("high overload wrong");
    a_block_mutes: assert property (blockIn [*4] ##0 cycleTick |=>
        !(alarm1Out | alarm2Out | lockoutOut | tripOut))
        else $error("blocked output");
    a_start_excl: assert property (!(startInd && blockedInd))
        else $error("start and blocked together");
    a_sf_unity: assert property (serviceFactorAlarm |->
        usedServiceFactor == 10'h064) else $error("factor not unity");
    a_amb_unity: assert property (usedAmbientK ==
        (ambientAlarm ? 10'h064 : 10'h000)) else $error("ambient k wrong");
    a_trip_tick: assert property ($rose(tripOut) |->
        $past(cycleTick)) else $error("trip off tick");
    c_trip: cover property ($rose(tripOut));
    c_block: cover property (blockIn && cycleTick);
    c_high: cover property (loadStatus == 2'h3);
endmodule : tolg_properties

bind tolg_output_logic tolg_properties i_props (.sys_clk, .reset_n,
    .cycleTick, .blockIn, .measCurrent, .pickupCurrent, .alarm1Out,
    .alarm2Out, .lockoutOut, .tripOut, .startInd, .blockedInd, .condition,
    .loadStatus, .serviceFactorAlarm, .ambientAlarm, .usedServiceFactor,
    .usedAmbientK);

// ### verification/tolg_partner.sv
// Far-side model: capacity source, cycle tick and blocking input
`timescale 1ns/1ps
module tolg_partner #(
    parameter int GAP = 8
) (
    input wire logic sys_clk,
    input wire logic [10:0] capSet,
    input wire logic [15:0] curSet,
    input wire logic blkSet,
    output logic cycleTick,
    output logic [10:0] thermalCapacity,
    output logic [15:0] measCurrent,
    output logic [15:0] pickupCurrent,
    output logic blockIn
);
    logic [7:0] cnt = 8'h00;
    always @(posedge sys_clk) begin
        cnt <= (cnt == 8'(GAP - 1)) ? 8'h00 : cnt + 8'h01;
    end
    assign cycleTick = (cnt == 8'(GAP - 1));
    assign thermalCapacity = capSet;
    assign measCurrent = curSet;
    assign pickupCurrent = 16'h0064;
    assign blockIn = blkSet;
endmodule : tolg_partner

// ### verification/test_thermal_overload_output_logic.sv
// Self-checking bench for the thermal overload output logic
`timescale 1ns/1ps
module test_thermal_overload_output_logic;
    logic sys_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic rdSeen = 1'b0, blkSet = 1'b0, cycleTick, blockIn;
    logic [7:0] regAddr = 8'h00, adrQ[$];
    logic [31:0] regWdata = 32'h0, regRdata, expQ[$], mskQ[$], stat;
    logic [10:0] capSet = 11'h000, thermalCapacity, lv2;
    logic [15:0] curSet = 16'h0000, measCurrent, pickupCurrent;
    logic [3:0] en, hit;
    logic [2:0] cnd;
    logic [1:0] li;
    int errCount = 0, cmpCount = 0, seed = 60;
    logic [7:0] rstAddr[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h2C};
    logic [10:0] rstVal[7] = '{11'h000, 11'h190, 11'h190, 11'h320, 11'h3E8,
        11'h000, 11'h000};
    logic [15:0] curTab[4] = '{16'h0000, 16'h0032, 16'h0096, 16'h012C};
    logic [2:0] modeCond[5] = '{3'h4, 3'h5, 3'h4, 3'h5, 3'h0};
    tolg_partner i_far (.sys_clk, .capSet, .curSet, .blkSet, .cycleTick,
        .thermalCapacity, .measCurrent, .pickupCurrent, .blockIn);
    tolg_output_logic #(.STEP_CYCLES(4)) i_dut (.sys_clk, .reset_n, .regAddr,
        .regWdata, .regWrite, .regRead, .regRdata, .cycleTick,
        .thermalCapacity, .measCurrent, .pickupCurrent, .blockIn,
        .alarm1Out(), .alarm2Out(), .lockoutOut(), .tripOut(), .startInd(),
        .blockedInd(), .condition(), .loadStatus(), .serviceFactorAlarm(),
        .ambientAlarm(), .usedServiceFactor(), .usedAmbientK());
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) rdSeen <= regRead;
    always @(negedge sys_clk) if (rdSeen) begin
        compare(adrQ.pop_front(), mskQ.pop_front(), expQ.pop_front());
    end
    task automatic compare(input logic [7:0] a, input logic [31:0] m, e);
        cmpCount++;
        if ((regRdata & m) !== (e & m)) begin
            errCount++;
            $display("unexpected reg %h exp %h got %h", a, e & m,
                regRdata & m);
        end
    endtask : compare
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a; regWdata <= d; regWrite <= 1'b1;
        @(posedge sys_clk) regWrite <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        adrQ.push_back(a); mskQ.push_back(m); expQ.push_back(e);
        regAddr <= a; regRead <= 1'b1;
        @(posedge sys_clk) regRead <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    task automatic ticks(input int n);
        int k = 0;
        repeat (n) do begin @(posedge sys_clk); k++; end
            while (!cycleTick && k < 200);
        if (k >= 200) begin
            errCount++;
            conclude();
        end else begin
            @(posedge sys_clk);
        end
    endtask : ticks
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        wr(8'h2C, 32'hFFFF);
        foreach (rstAddr[i]) begin
            rd(rstAddr[i], 32'hFFFFF, {21'h0, rstVal[i]});
        end
        repeat (20) begin
            en = 4'($random(seed));
            lv2 = 11'($unsigned($random(seed)) % 1200);
            li = 2'($random(seed));
            wr(8'h00, {28'h0, en});
            wr(8'h08, {21'h0, lv2});
            capSet <= 11'($unsigned($random(seed)) % 1200);
            curSet <= curTab[li];
            ticks(2);
            hit = en & {capSet >= 11'h3E8, capSet >= 11'h320, capSet >= lv2,
                capSet >= 11'h190};
            cnd = hit[3] ? 3'h4 : hit[2] ? 3'h3 : hit[1] ? 3'h2
                : {2'h0, hit[0]};
            stat = {20'h0, li, cnd, 3'h0, hit};
            rd(8'h24, 32'hF8F, stat);
        end
        capSet <= 11'h3E8;
        for (int m = 0; m < 5; m++) begin
            wr(8'h00, 32'h8 | (m << 4));
            ticks(2);
            stat = {22'h0, modeCond[m], 3'h0, m == 0, 3'h0};
            rd(8'h24, 32'h388, stat);
        end
        wr(8'h00, 32'h8); blkSet <= 1'b1; ticks(2);
        rd(8'h24, 32'h48, 32'h40);
        blkSet <= 1'b0; ticks(2);
        rd(8'h24, 32'h28, 32'h28);
        capSet <= 11'h000; wr(8'h14, 32'h3); ticks(2);
        capSet <= 11'h3E8; ticks(2);
        rd(8'h24, 32'h28, 32'h20);
        ticks(2);
        rd(8'h24, 32'h28, 32'h28);
        capSet <= 11'h000; ticks(2); capSet <= 11'h3E8; ticks(1);
        blkSet <= 1'b1; ticks(3);
        rd(8'h24, 32'h68, 32'h40);
        blkSet <= 1'b0; wr(8'h18, 32'h0); wr(8'h1C, 32'h0);
        rd(8'h24, 32'h3000, 32'h3000);
        rd(8'h28, 32'hFFFFF, {12'h0, 10'h064, 10'h064});
        wr(8'h18, 32'h0C8); wr(8'h1C, 32'h064);
        rd(8'h28, 32'hFFFFF, {12'h0, 10'h000, 10'h0C8});
        wr(8'h20, 32'h1F5);
        rd(8'h28, 32'hFFC00, {12'h0, 10'h064, 10'h000});
        conclude();
    end
endmodule : test_thermal_overload_output_logic
